// ---- hw/pmta_device.sv ----
// table access engine with holding row and self-timed programming
module pmta_device
  import pmta_pkg::*;
#(
  parameter int PROG_CYC = PMTA_PROG_CYC,
  parameter int MEM_WORDS = 4096
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // core link
  pmta_if.device lnk,
  // status
  output logic prog_done
);
  localparam int MAW = $clog2(MEM_WORDS);
  // program array and the row of holding registers; neither is reset
  logic [23:0] mem [MEM_WORDS];
  logic [23:0] hold_q [PMTA_ROW_WORDS];
  logic [23:0] hold_d [PMTA_ROW_WORDS];
  logic [23:0] wmerge;
  // read answer
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic ack_q;
  logic ack_d;
  // unlock progress: 0 idle, 1 first key seen, 2 armed
  logic [1:0] key_q;
  logic [1:0] key_d;
  // self-timed programming
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;
  logic [PMTA_PWA_W-1:0] row_base_q;
  logic [PMTA_PWA_W-1:0] row_base_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  // address decode
  logic [23:0] paddr;
  logic [PMTA_PWA_W-1:0] wsel;
  logic [PMTA_ROW_AW-1:0] hsel;
  logic [MAW-PMTA_ROW_AW-1:0] row_hi;
  logic [23:0] rword;
  logic [7:0] rlow_byte;
  logic [7:0] rhigh_byte;
  logic bsel;
  logic is_read;
  logic do_wr;
  logic arm_ok;
  logic last_cyc;
  assign paddr = {lnk.table_page_register, lnk.effective_address}; // [R5]
  assign wsel = paddr[23:1]; // [R6] [R8]
  assign hsel = wsel[PMTA_ROW_AW-1:0]; // [R15] [R13]
  assign bsel = lnk.byte_mode & paddr[0]; // [R7]
  // reads see the programmed array, never the holding row
  assign rword = mem[wsel[MAW-1:0]];
  // byte mode: odd address picks the upper byte of the lane
  assign rlow_byte = bsel ? rword[15:8] : rword[7:0]; // [R7]
  assign rhigh_byte = bsel ? PMTA_PHANTOM : rword[23:16]; // [R3]
  assign is_read = lnk.req & ~lnk.op[1];
  // the row under programming must not change beneath the copy
  assign do_wr = lnk.req & ~busy_q & lnk.op[1]; // [R21]
  assign arm_ok = lnk.start & (key_q == 2'd2) & ~busy_q; // [R12]
  assign last_cyc = busy_q & (cnt_q == 16'd1);
  // target row is latched at start; later addresses do not move it
  assign row_hi = row_base_q[MAW-1:PMTA_ROW_AW];
  // read path: answer one cycle after the request
  always_comb
  begin
    ack_d = lnk.req;
    rdata_d = rdata_q;
    if (is_read)
    begin
      unique case (lnk.op)
        PMTA_OP_RDL:
          rdata_d = lnk.byte_mode ? {8'h00, rlow_byte} : rword[15:0]; // [R1]
        PMTA_OP_RDH:
          rdata_d = lnk.byte_mode ? {8'h00, rhigh_byte} : {PMTA_PHANTOM, rword[23:16]}; // [R2] [R3] [R4]
        PMTA_OP_WTL, PMTA_OP_WTH:
          rdata_d = rdata_q;
      endcase
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      rdata_q <= 16'h0000;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end
  // unlock: a stray key, request or start throws the sequence away
  always_comb
  begin
    key_d = key_q;
    if (lnk.key_we) // [R19]
    begin
      if (lnk.key_data == PMTA_KEY1)
        key_d = 2'd1;
      else if (key_q == 2'd1 && lnk.key_data == PMTA_KEY2)
        key_d = 2'd2;
      else
        key_d = 2'd0;
    end
    else if (lnk.start || lnk.req)
      key_d = 2'd0;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      key_q <= 2'd0;
    else
      key_q <= key_d;
  end
  // self-timed row program: busy stands for PROG_CYC cycles, then drops
  always_comb
  begin
    busy_d = busy_q;
    done_d = 1'b0;
    row_base_d = row_base_q;
    cnt_d = cnt_q;
    if (arm_ok)
    begin
      busy_d = 1'b1;
      cnt_d = 16'(PROG_CYC);
      row_base_d = wsel;
    end
    else if (busy_q)
    begin
      cnt_d = cnt_q - 16'd1;
      if (last_cyc)
      begin
        busy_d = 1'b0; // [R20]
        done_d = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      row_base_q <= '0;
      cnt_q <= 16'h0000;
    end
    else
    begin
      busy_q <= busy_d;
      done_q <= done_d;
      row_base_q <= row_base_d;
      cnt_q <= cnt_d;
    end
  end
  // merge write data into the addressed holding entry
  always_comb
  begin
    wmerge = hold_q[hsel];
    unique case (lnk.op)
      PMTA_OP_WTL:
      begin
        if (!lnk.byte_mode)
          wmerge[15:0] = lnk.wdata; // [R1]
        else if (bsel)
          wmerge[15:8] = lnk.wdata[7:0]; // [R9]
        else
          wmerge[7:0] = lnk.wdata[7:0]; // [R9]
      end
      PMTA_OP_WTH:
      begin
        // odd byte address in byte mode is the phantom byte
        if (!bsel)
          wmerge[23:16] = lnk.wdata[7:0]; // [R2] [R3]
      end
      PMTA_OP_RDL, PMTA_OP_RDH:
        wmerge = hold_q[hsel];
    endcase
  end
  // holding row: loaded only by table writes, never seen as data [R10] [R11] [R14]
  always_comb
  begin
    for (int i = 0; i < PMTA_ROW_WORDS; i++)
      hold_d[i] = hold_q[i];
    if (do_wr) // [R15]
      hold_d[hsel] = wmerge;
  end
  always_ff @(posedge mclk)
  begin
    hold_q <= hold_d;
  end
  // whole row lands in the array on the last programming cycle
  always_ff @(posedge mclk)
  begin
    if (last_cyc)
    begin
      for (int i = 0; i < PMTA_ROW_WORDS; i++)
        mem[{row_hi, PMTA_ROW_AW'(i)}] <= hold_q[i]; // [R14]
    end
  end
  assign lnk.rdata = rdata_q;
  assign lnk.ack = ack_q;
  assign lnk.busy = busy_q; // [R20]
  assign prog_done = done_q;
endmodule : pmta_device

// ---- hw/pmta_pkg.sv ----
// package for the program memory table access block
// Summary of operation
// R1: low ops access word bits 15:0
// R2: high ops access word bits 23:16
// R3: phantom byte reads zero, writes ignored
// R4: low and high spaces share addresses
// R5: address is page byte plus effective address
// R6: upper 23 address bits select word
// R7: byte mode: address bit0 selects byte
// R8: word mode ignores address bit0
// R9: byte write uses source low byte only
// R10: table writes load holding buffer only
// R11: holding buffers reachable only by table writes
// R12: programming starts only by key sequence
// R13: pages of 512, rows of 64 words
// R14: 64 holding registers, one row
// R15: write address selects holding entry
// R16: single-buffer parts program before next load
// R17: word mode steps address by two
// R18: load page and address before reading
// R19: key 0x55 then 0xaa unlocks start
// R20: start bit self-clears when operation done
// R21: buffers frozen while programming
package pmta_pkg;
  localparam int PMTA_ROW_WORDS = 64;
  localparam int PMTA_PAGE_WORDS = 512;
  localparam int PMTA_ROW_AW = 6;
  localparam int PMTA_PWA_W = 23;
  localparam logic [7:0] PMTA_KEY1 = 8'h55;
  localparam logic [7:0] PMTA_KEY2 = 8'haa;
  localparam logic [7:0] PMTA_PHANTOM = 8'h00;
  localparam logic [23:0] PMTA_ERASED = 24'hffffff;
  // self-timed program duration
  localparam int PMTA_PROG_NS = 8000;
  localparam int PMTA_CLK_NS = 8;
  localparam int PMTA_PROG_CYC = (PMTA_PROG_NS + PMTA_CLK_NS - 1) / PMTA_CLK_NS;
  typedef enum logic [1:0] {
    PMTA_OP_RDL = 2'b00,
    PMTA_OP_RDH = 2'b01,
    PMTA_OP_WTL = 2'b10,
    PMTA_OP_WTH = 2'b11
  } pmta_op_e;
endpackage : pmta_pkg

// ---- hw/pmta_if.sv ----
// link between core and table access engine
interface pmta_if;
  import pmta_pkg::*;
  logic req;
  pmta_op_e op;
  logic byte_mode;
  logic [7:0] table_page_register;
  logic [15:0] effective_address;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic key_we;
  logic [7:0] key_data;
  logic start;
  logic busy;
  modport device (input req, op, byte_mode, table_page_register, effective_address, wdata, key_we, key_data,
    start, output rdata, ack, busy);
  modport core (output req, op, byte_mode, table_page_register, effective_address, wdata, key_we, key_data,
    start, input rdata, ack, busy);
endinterface : pmta_if

// ---- hw/pmta_core.sv ----
// core-side sequencer issuing table ops and unlock sequence
module pmta_core
  import pmta_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // user command
  input wire logic cmd_valid,
  input wire pmta_op_e cmd_op,
  input wire logic cmd_byte,
  input wire logic [23:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_program,
  output logic cmd_ready,
  output logic [15:0] cmd_rdata,
  output logic cmd_done,
  // device link
  pmta_if.core lnk
);
  typedef enum logic [2:0] {
    PMTA_C_IDLE = 3'b000,
    PMTA_C_OP = 3'b001,
    PMTA_C_K1 = 3'b010,
    PMTA_C_K2 = 3'b011,
    PMTA_C_GO = 3'b100,
    PMTA_C_WAIT = 3'b101
  } pmta_cst_e;
  pmta_cst_e st_q, st_d;
  logic [15:0] rd_q, rd_d;
  logic done_q, done_d;
  logic [23:0] a_q, a_d;
  always_comb
  begin
    st_d = st_q;
    rd_d = rd_q;
    done_d = 1'b0;
    a_d = a_q;
    unique case (st_q)
      PMTA_C_IDLE:
        if (cmd_valid)
        begin
          a_d = cmd_addr; // [R18]
          st_d = cmd_program ? PMTA_C_K1 : PMTA_C_OP;
        end
      PMTA_C_OP:
      begin
        st_d = PMTA_C_IDLE;
        done_d = 1'b1;
      end
      PMTA_C_K1: st_d = PMTA_C_K2; // [R19]
      PMTA_C_K2: st_d = PMTA_C_GO;
      PMTA_C_GO: st_d = PMTA_C_WAIT; // [R12]
      PMTA_C_WAIT:
        if (!lnk.busy) // [R16]
        begin
          st_d = PMTA_C_IDLE;
          done_d = 1'b1;
        end
      default: st_d = PMTA_C_IDLE;
    endcase
    if (st_q == PMTA_C_IDLE)
      rd_d = lnk.rdata;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= PMTA_C_IDLE;
      rd_q <= 16'h0000;
      done_q <= 1'b0;
      a_q <= 24'h000000;
    end
    else
    begin
      st_q <= st_d;
      rd_q <= rd_d;
      done_q <= done_d;
      a_q <= a_d;
    end
  end
  assign lnk.req = (st_q == PMTA_C_OP);
  assign lnk.op = cmd_op;
  assign lnk.byte_mode = cmd_byte;
  assign lnk.table_page_register = a_q[23:16]; // [R18]
  assign lnk.effective_address = a_q[15:0];
  assign lnk.wdata = cmd_wdata;
  assign lnk.key_we = (st_q == PMTA_C_K1) || (st_q == PMTA_C_K2);
  assign lnk.key_data = (st_q == PMTA_C_K1) ? PMTA_KEY1 : PMTA_KEY2;
  assign lnk.start = (st_q == PMTA_C_GO);
  assign cmd_ready = (st_q == PMTA_C_IDLE);
  assign cmd_rdata = rd_q;
  assign cmd_done = done_q;
endmodule : pmta_core

// ---- testbench/pmta_monitor.sv ----
// assertions on the core-to-device link
module pmta_monitor
  import pmta_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // link
  input wire logic req,
  input wire pmta_op_e op,
  input wire logic byte_mode,
  input wire logic [15:0] effective_address,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic key_we,
  input wire logic [7:0] key_data,
  input wire logic start,
  input wire logic busy,
  input wire logic prog_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_ack_follows:
    assert property (req |=> ack) else $error("no ack after request");
  a_ack_cause:
    assert property (ack |-> $past(req)) else $error("ack without request");
  a_rdata_hold:
    assert property (!$past(req && !op[1]) |-> $stable(rdata)) else $error("rdata moved without read");
  a_high_upper:
    assert property (ack && $past(req && op == PMTA_OP_RDH && !byte_mode) |-> rdata[15:8] == 8'h00)
      else $error("high word upper byte not zero");
  a_phantom_zero:
    assert property (ack && $past(req && op == PMTA_OP_RDH && byte_mode && effective_address[0])
      |-> rdata[7:0] == PMTA_PHANTOM) else $error("phantom byte not zero");
  a_key_gate:
    assert property ($rose(busy) |-> $past(start) && $past(key_we, 2) && $past(key_data, 2) == PMTA_KEY2
      && $past(key_we, 3) && $past(key_data, 3) == PMTA_KEY1) else $error("busy without key");
  a_busy_len:
    assert property ($rose(busy) |-> busy [*4] ##1 !busy) else $error("busy length wrong");
  a_done_end:
    assert property ($fell(busy) |-> ##[0:1] prog_done) else $error("no done at end");
endmodule : pmta_monitor

// ---- testbench/pmta_tb.sv ----
// self-checking bench for the table access pair
module pmta_tb
  import pmta_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, cmd_valid, cmd_byte, cmd_program, cmd_ready, cmd_done, prog_done;
  pmta_op_e cmd_op;
  logic [23:0] cmd_addr;
  logic [15:0] cmd_wdata, cmd_rdata;
  logic [23:0] mdl [64];
  int n_mismatch, checked, seed;
  pmta_if lnk ();
  always #4 mclk = ~mclk;
  pmta_core u_pmta_core (.mclk, .rst, .cmd_valid, .cmd_op, .cmd_byte, .cmd_addr, .cmd_wdata, .cmd_program,
    .cmd_ready, .cmd_rdata, .cmd_done, .lnk(lnk.core));
  pmta_device #(.PROG_CYC(4)) u_pmta_device (.mclk, .rst, .lnk(lnk.device), .prog_done);
  pmta_monitor u_pmta_monitor (.mclk, .rst, .req(lnk.req), .op(lnk.op), .byte_mode(lnk.byte_mode),
    .effective_address(lnk.effective_address), .rdata(lnk.rdata), .ack(lnk.ack), .key_we(lnk.key_we),
    .key_data(lnk.key_data), .start(lnk.start), .busy(lnk.busy), .prog_done);
  function automatic logic [15:0] rd_exp(pmta_op_e o, logic b, logic a0, logic [23:0] w);
    if (o == PMTA_OP_RDL)
      return b ? {8'h00, a0 ? w[15:8] : w[7:0]} : w[15:0];
    return (b && a0) ? 16'h0000 : {8'h00, w[23:16]};
  endfunction : rd_exp
  function automatic logic [23:0] wr_exp(pmta_op_e o, logic b, logic a0, logic [15:0] d, logic [23:0] w);
    if (o == PMTA_OP_WTL && !b)
      w[15:0] = d;
    else if (o == PMTA_OP_WTL)
      w[8*a0 +: 8] = d[7:0];
    else if (!(b && a0))
      w[23:16] = d[7:0];
    return w;
  endfunction : wr_exp
  task automatic run(pmta_op_e o, logic b, logic p, logic [23:0] a, logic [15:0] d);
    int n;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_byte <= b;
    cmd_program <= p;
    cmd_addr <= a;
    cmd_wdata <= d;
    // outputs are looked at on the falling edge, where they are settled
    @(negedge mclk);
    while (cmd_ready !== 1'b1)
      @(negedge mclk);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 500; n++)
    begin
      @(negedge mclk);
      if (cmd_done === 1'b1)
        break;
    end
    if (n == 500)
    begin
      $display("[ERR] cmd_done exp 1 got 0");
      n_mismatch++;
    end
    // read data reaches cmd_rdata one cycle after done
    @(negedge mclk);
  endtask : run
  task automatic chk(logic [15:0] e, logic [15:0] s);
    checked++;
    if (s !== e)
    begin
      $display("[ERR] rdata exp %h got %h", e, s);
      n_mismatch++;
    end
  endtask : chk
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  initial
  begin
    #400000;
    n_mismatch++;
    close_out();
  end
  initial
  begin
    logic [15:0] rb, ea, d;
    pmta_op_e o;
    seed = 32'hf7ed428d;
    mclk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = PMTA_OP_RDL;
    cmd_byte = 1'b0;
    cmd_program = 1'b0;
    cmd_addr = 24'h000000;
    cmd_wdata = 16'h0000;
    n_mismatch = 0;
    checked = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (3)
    begin
      rb = 16'h1f80 & 16'($random(seed));
      // whole row in word mode, odd address bit mixed in
      for (int i = 0; i < 128; i++)
      begin
        o = i[0] ? PMTA_OP_WTH : PMTA_OP_WTL;
        ea = rb + 16'(i & 126) + 16'($random(seed) & 1);
        d = 16'($random(seed));
        run(o, 1'b0, 1'b0, {8'($random(seed)), ea}, d);
        mdl[i/2] = wr_exp(o, 1'b0, ea[0], d, mdl[i/2]);
      end
      repeat (40)
      begin
        o = ($random(seed) & 1) ? PMTA_OP_WTH : PMTA_OP_WTL;
        ea = rb + 16'($random(seed) & 127);
        d = 16'($random(seed));
        run(o, 1'b1, 1'b0, {8'h00, ea}, d);
        mdl[ea[6:1]] = wr_exp(o, 1'b1, ea[0], d, mdl[ea[6:1]]);
      end
      run(PMTA_OP_WTL, 1'b0, 1'b1, {8'h00, rb}, 16'h0000);
      for (int k = 0; k < 512; k++)
      begin
        o = k[0] ? PMTA_OP_RDH : PMTA_OP_RDL;
        ea = rb + 16'((k >> 2) & 126) + 16'(k[2]);
        run(o, k[1], 1'b0, {8'($random(seed)), ea}, 16'h0000);
        chk(rd_exp(o, k[1], ea[0], mdl[ea[6:1]]), cmd_rdata);
      end
    end
    close_out();
  end
endmodule : pmta_tb
